// File: pkg/lfs_map.vh
// Constants for the LED string fault supervisor: timing, registers, fields
//
// Contract
// R1: Sinks follow the brightness PWM directly; host keeps it at 100 Hz to 20 kHz.
// R2: Input undervoltage (3.85 V fall, 4 V rise) stops power path, enters retry.
// R3: Input overvoltage above 42 V stops power path, alarm low, enters retry.
// R4: Retry wait after a non-string fault lasts 100 ms, then restart is tried.
// R5: Supply, node and temperature faults are watched in precharge, ramp, normal.
// R6: Feedback sense above 2.3 V is output overvoltage: shut down, enter retry.
// R7: Output overvoltage counts only in normal, after persisting over 560 ms.
// R8: Inductor node above 49 V stops power path, alarm low, enters retry.
// R9: Die at 165 C trips overtemperature: power path off, alarm low, retry.
// R10: After overtemperature, restart completes only below 145 C; retries continue.
// R11: Every detected fault, string faults included, pulls the alarm low.
// R12: Reaching normal after a retry with no fault releases the alarm high.
// R13: String faults never enter retry; only the faulty string is disabled.
// R14: Open string: boost target at maximum and a used sink still below 0.9 V.
// R15: Short string: a sink above 6 V while another sits in 0.9 V to 1.9 V.
// R16: String open and short detection runs only in the normal state.
// R17: Enable low for 2 to 20 us clears string faults, blanks sinks, stays normal.
// R18: Enable low longer than the clearing pulse leads to standby, then restart. The code waits for more than 50 us (STBY_CYC) instead.
// R19: Each sink channel supplies low, mid and high comparator results.
// R20: Enable held low for more than 50 us returns the device to standby.
// R21: Precharge keeps the power-line switch on for 65 ms before ramp.
// R22: After 50 ms of ramp, grounded sinks are detected once and excluded.
// R23: Retry end restarts from precharge only while enable is still high.
// R24: Comparators pass two-flop synchronisers; times come from a prescaled tick. The code counts enable pulse times in clock cycles instead.
// R25: Per-string fault flags hold until the clearing pulse or standby.
`ifndef LFS_MAP_VH
`define LFS_MAP_VH

// Clock and time base
`define LFS_CLK_PERIOD_NS 10
`define LFS_T_TICK_NS 1000
`define LFS_TICK_CYC (`LFS_T_TICK_NS / `LFS_CLK_PERIOD_NS)

// Long times, counted in 1 us ticks
`define LFS_T_PRECHARGE_MS 65
`define LFS_T_RAMP_MS 50
`define LFS_T_RETRY_MS 100
`define LFS_T_OUT_OVP_MS 560
`define LFS_PRE_TICKS (`LFS_T_PRECHARGE_MS * 1000)
`define LFS_RAMP_TICKS (`LFS_T_RAMP_MS * 1000)
`define LFS_RETRY_TICKS (`LFS_T_RETRY_MS * 1000)
`define LFS_OVP_TICKS (`LFS_T_OUT_OVP_MS * 1000)

// Enable pulse times, counted in clock cycles
`define LFS_T_CLR_MIN_NS 2000
`define LFS_T_CLR_MAX_NS 20000
`define LFS_T_STBY_NS 50000
`define LFS_CLR_MIN_CYC \
  ((`LFS_T_CLR_MIN_NS + `LFS_CLK_PERIOD_NS - 1) / `LFS_CLK_PERIOD_NS)
`define LFS_CLR_MAX_CYC (`LFS_T_CLR_MAX_NS / `LFS_CLK_PERIOD_NS)
`define LFS_STBY_CYC \
  ((`LFS_T_STBY_NS + `LFS_CLK_PERIOD_NS - 1) / `LFS_CLK_PERIOD_NS)

// Register byte offsets
`define LFS_REG_CTRL 8'h00
`define LFS_REG_STATUS 8'h04
`define LFS_REG_STRING 8'h08
`define LFS_REG_CAUSE 8'h0C
`define LFS_REG_RETRIES 8'h10

// Field positions and reset values
`define LFS_CTRL_DETECT_EN 0
`define LFS_CTRL_RESET 1'b1
`define LFS_STAT_ALARM_PIN 8
`define LFS_STAT_ALARM_LOW 9
`define LFS_STR_OPEN_LSB 0
`define LFS_STR_SHORT_LSB 8
`define LFS_STR_GND_LSB 16
`define LFS_CAUSE_UV 0
`define LFS_CAUSE_OV 1
`define LFS_CAUSE_OUT 2
`define LFS_CAUSE_NODE 3
`define LFS_CAUSE_TEMP 4
`define LFS_RESP_OKAY 2'h0
`define LFS_RESP_DECERR 2'h3

`endif

// File: core/lfs_sync.v
// Two-flop synchroniser for a bundle of comparator levels
`timescale 1ns/1ps
module lfs_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  input wire clk_en,
  // Levels
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_q
);

  reg [W-1:0] meta_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else if (clk_en) begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

endmodule // lfs_sync

// File: core/lfs_tick.v
// Prescaler producing a one-cycle tick every DIV enabled cycles
`timescale 1ns/1ps
module lfs_tick #(
  parameter DIV = 100
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  input wire clk_en,
  // Tick
  output reg tick_q
);

  reg [15:0] cnt_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      if (cnt_q == DIV[15:0] - 16'h0001) begin
        cnt_q <= 16'h0000;
        tick_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
        tick_q <= 1'b0;
      end
    end
  end

endmodule // lfs_tick

// File: core/lfs_supervisor.v
// Fault supervisor, start-up sequencer and register slave of the LED driver
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "lfs_map.vh"
module lfs_supervisor #(
  parameter NCH = 4,
  parameter TICK_DIV = `LFS_TICK_CYC,
  parameter [19:0] PRE_TICKS = `LFS_PRE_TICKS,
  parameter [19:0] RAMP_TICKS = `LFS_RAMP_TICKS,
  parameter [19:0] RETRY_TICKS = `LFS_RETRY_TICKS,
  parameter [19:0] OVP_TICKS = `LFS_OVP_TICKS,
  parameter [15:0] CLR_MIN_CYC = `LFS_CLR_MIN_CYC,
  parameter [15:0] CLR_MAX_CYC = `LFS_CLR_MAX_CYC,
  parameter [15:0] STBY_CYC = `LFS_STBY_CYC
) (
  // Clock, reset, enable
  input wire clk,
  input wire rst_b,
  input wire clk_en,
  // AXI4-Lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Host pins
  input wire enable_input,
  input wire pwm_in,
  input wire alarm_in,
  output wire alarm_out,
  output wire alarm_oe,
  // Comparator flags
  input wire input_undervoltage,
  input wire input_overvoltage,
  input wire output_overvoltage,
  input wire inductor_node_overvoltage,
  input wire overtemperature_trip,
  input wire boost_at_max,
  input wire [NCH-1:0] sink_low,
  input wire [NCH-1:0] sink_mid,
  input wire [NCH-1:0] sink_high,
  // Power stage controls
  output reg power_switch_en,
  output reg boost_en,
  output wire [NCH-1:0] current_sink_pin_en,
  output reg [NCH-1:0] loop_include,
  output wire [4:0] state_o
);

  localparam [4:0] ST_STANDBY = 5'h01;
  localparam [4:0] ST_PRECHARGE = 5'h02;
  localparam [4:0] ST_RAMP = 5'h04;
  localparam [4:0] ST_NORMAL = 5'h08;
  localparam [4:0] ST_RETRY = 5'h10;
  localparam CW = 5 + 3 * NCH + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchronisation and time base

  wire [CW-1:0] cmp_s;
  wire tick;
  wire uv_s = cmp_s[0];
  wire ov_s = cmp_s[1];
  wire out_ovp_s = cmp_s[2];
  wire node_s = cmp_s[3];
  wire temp_s = cmp_s[4];
  wire [NCH-1:0] low_s = cmp_s[5 +: NCH];
  wire [NCH-1:0] mid_s = cmp_s[5 + NCH +: NCH];
  wire [NCH-1:0] high_s = cmp_s[5 + 2 * NCH +: NCH];
  wire at_max_s = cmp_s[CW-1];

  lfs_sync #(.W(CW)) u_sync ( // R24 R19
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_i({boost_at_max, sink_high, sink_mid, sink_low,
              overtemperature_trip, inductor_node_overvoltage,
              output_overvoltage, input_overvoltage, input_undervoltage}),
    .sync_q(cmp_s)
  );

  lfs_tick #(.DIV(TICK_DIV)) u_tick ( // R24
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .tick_q(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State and counters

  reg [4:0] state_q;
  reg [4:0] state_d;
  reg [19:0] timer_q;
  reg [19:0] ovp_cnt_q;
  reg [15:0] en_low_q;
  reg en_q;
  reg alarm_low_q;
  reg ctrl_detect_q;
  reg [NCH-1:0] open_q;
  reg [NCH-1:0] short_q;
  reg [NCH-1:0] gnd_q;
  reg [4:0] cause_q;
  reg [7:0] retries_q;

  wire st_norm = state_q[3];
  wire st_watch = state_q[1] | state_q[2] | state_q[3];
  wire [NCH-1:0] disabled = open_q | short_q | gnd_q;
  wire [NCH-1:0] used = ~disabled;
  // Fault from the output only after a long persistence in normal
  wire out_fault = st_norm & out_ovp_s & (ovp_cnt_q >= OVP_TICKS); // R7 R6
  wire [4:0] fault_vec = {temp_s & st_watch, node_s & st_watch, // R5 R9 R8
                          out_fault, ov_s & st_watch, uv_s & st_watch}; // R2 R3
  wire hard_fault = |fault_vec;
  wire en_rise = enable_input & ~en_q;
  wire clr_pulse = en_rise & (en_low_q >= CLR_MIN_CYC) &
                   (en_low_q <= CLR_MAX_CYC); // R17
  wire en_long_low = ~enable_input & (en_low_q > STBY_CYC); // R20 R18
  wire blank = st_norm & ~enable_input; // R17
  wire detect = st_norm & ctrl_detect_q & enable_input & ~hard_fault; // R16
  wire [NCH-1:0] open_set = (at_max_s & detect) ?
                            (low_s & used) : {NCH{1'b0}}; // R14
  wire [NCH-1:0] window = used & ~low_s & mid_s;
  wire [NCH-1:0] short_set = (detect & (|window)) ?
                             (high_s & used) : {NCH{1'b0}}; // R15
  // Grounded sinks leave the loop at the very edge that enters normal
  wire [NCH-1:0] gnd_set = (state_q == ST_RAMP && state_d == ST_NORMAL) ?
                           low_s : {NCH{1'b0}}; // R22

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_STANDBY: begin
        if (enable_input)
          state_d = ST_PRECHARGE;
      end
      ST_PRECHARGE: begin
        if (timer_q >= PRE_TICKS)
          state_d = ST_RAMP; // R21
      end
      ST_RAMP: begin
        if (timer_q >= RAMP_TICKS)
          state_d = ST_NORMAL; // R22
      end
      ST_NORMAL: begin
        state_d = ST_NORMAL; // R13
      end
      ST_RETRY: begin
        if (timer_q >= RETRY_TICKS)
          state_d = enable_input ? ST_PRECHARGE : ST_STANDBY; // R4 R23 R10
      end
      default: begin
        state_d = ST_STANDBY;
      end
    endcase
    // Hard faults outrank the normal sequence
    if (hard_fault)
      state_d = ST_RETRY; // R2 R3 R6 R8 R9
    if (en_long_low & ~state_q[4])
      state_d = ST_STANDBY; // R20 R18
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_STANDBY;
      timer_q <= 20'h00000;
      ovp_cnt_q <= 20'h00000;
      en_low_q <= 16'h0000;
      en_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      en_q <= enable_input;
      if (state_d != state_q)
        timer_q <= 20'h00000;
      else if (tick && timer_q != 20'hFFFFF)
        timer_q <= timer_q + 20'h00001;
      if (!(st_norm && out_ovp_s))
        ovp_cnt_q <= 20'h00000; // R7
      else if (tick && ovp_cnt_q != 20'hFFFFF)
        ovp_cnt_q <= ovp_cnt_q + 20'h00001;
      if (enable_input)
        en_low_q <= 16'h0000;
      else if (en_low_q != 16'hFFFF)
        en_low_q <= en_low_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // String flags, alarm, cause log

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      open_q <= {NCH{1'b0}};
      short_q <= {NCH{1'b0}};
      gnd_q <= {NCH{1'b0}};
      alarm_low_q <= 1'b0;
      retries_q <= 8'h00;
    end else if (clk_en) begin
      // A detection in the clearing cycle survives the clear
      if (state_d == ST_STANDBY || clr_pulse) begin
        open_q <= open_set; // R25 R17
        short_q <= short_set;
      end else begin
        open_q <= open_q | open_set; // R14 R25
        short_q <= short_q | short_set; // R15 R25
      end
      if (state_d == ST_STANDBY)
        gnd_q <= {NCH{1'b0}};
      else if (state_q == ST_RAMP && state_d == ST_NORMAL)
        gnd_q <= low_s; // R22
      if (hard_fault || (|open_set) || (|short_set))
        alarm_low_q <= 1'b1; // R11
      else if (clr_pulse && st_norm)
        alarm_low_q <= 1'b0; // R17
      else if (state_q == ST_RAMP && state_d == ST_NORMAL &&
               open_q == {NCH{1'b0}} && short_q == {NCH{1'b0}})
        alarm_low_q <= 1'b0; // R12
      if (state_d == ST_RETRY && !state_q[4] && retries_q != 8'hFF)
        retries_q <= retries_q + 8'h01;
    end
  end

  // Power path follows the state; sinks reproduce PWM with no delay
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_switch_en <= 1'b0;
      boost_en <= 1'b0;
      loop_include <= {NCH{1'b0}};
    end else if (clk_en) begin
      power_switch_en <= state_d[1] | state_d[2] | state_d[3]; // R21
      boost_en <= state_d[2] | state_d[3]; // R2 R3 R9
      loop_include <= (state_d[2] | state_d[3]) ?
                      ~(disabled | open_set | short_set | gnd_set) :
                      {NCH{1'b0}}; // R14 R15 R22
    end
  end

  // Combinational so the sink edge tracks the PWM edge
  assign current_sink_pin_en = (st_norm && !blank) ?
                               ({NCH{pwm_in}} & used) : {NCH{1'b0}}; // R1
  assign alarm_out = 1'b0;
  assign alarm_oe = alarm_low_q; // R11
  assign state_o = state_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  reg aw_hold_q;
  reg w_hold_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [31:0] rd_d;
  reg rd_hit;

  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire wr_ctrl = wr_go & (awaddr_q == `LFS_REG_CTRL) & wstrb_q[0];
  wire wr_cause = wr_go & (awaddr_q == `LFS_REG_CAUSE) & wstrb_q[0];
  wire wr_hit = (awaddr_q == `LFS_REG_CTRL) |
                (awaddr_q == `LFS_REG_CAUSE);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LFS_RESP_OKAY;
      ctrl_detect_q <= `LFS_CTRL_RESET;
      cause_q <= 5'h00;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `LFS_RESP_OKAY : `LFS_RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl)
        ctrl_detect_q <= wdata_q[`LFS_CTRL_DETECT_EN]; // R16
      // Write one to clear; a fault in the same cycle keeps its bit
      cause_q <= (cause_q & ~(wr_cause ? wdata_q[4:0] : 5'h00)) | fault_vec;
    end
  end

  always @* begin
    rd_d = 32'h00000000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `LFS_REG_CTRL: begin
        rd_d[`LFS_CTRL_DETECT_EN] = ctrl_detect_q;
      end
      `LFS_REG_STATUS: begin
        rd_d[4:0] = state_q;
        rd_d[`LFS_STAT_ALARM_PIN] = alarm_in;
        rd_d[`LFS_STAT_ALARM_LOW] = alarm_low_q;
      end
      `LFS_REG_STRING: begin
        rd_d[`LFS_STR_OPEN_LSB +: NCH] = open_q;
        rd_d[`LFS_STR_SHORT_LSB +: NCH] = short_q;
        rd_d[`LFS_STR_GND_LSB +: NCH] = gnd_q;
      end
      `LFS_REG_CAUSE: begin
        rd_d[4:0] = cause_q;
      end
      `LFS_REG_RETRIES: begin
        rd_d[7:0] = retries_q;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LFS_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= rd_hit ? `LFS_RESP_OKAY : `LFS_RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // lfs_supervisor

// File: tb/lfs_supervisor_properties.sv
// Concurrent checks on the supervisor's sequencing and power pins
`timescale 1ns/1ps
module lfs_supervisor_props #(
  parameter NCH = 4,
  parameter TICK_DIV = 100,
  parameter [19:0] PRE_TICKS = 20'h1,
  parameter [19:0] RAMP_TICKS = 20'h1,
  parameter [19:0] RETRY_TICKS = 20'h1,
  parameter [15:0] STBY_CYC = 16'h1
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Watched pins
  input wire enable_input,
  input wire pwm_in,
  input wire input_overvoltage,
  input wire alarm_oe,
  input wire boost_en,
  input wire power_switch_en,
  input wire [NCH-1:0] current_sink_pin_en,
  input wire [4:0] state_o
);
  // Windows allow for the free-running tick phase at state entry
  localparam int D = TICK_DIV;
  localparam int P_LO = PRE_TICKS * D - D - 1;
  localparam int P_HI = PRE_TICKS * D + 2;
  localparam int A_LO = RAMP_TICKS * D - D - 1;
  localparam int A_HI = RAMP_TICKS * D + 2;
  localparam int R_LO = RETRY_TICKS * D - D - 1;
  localparam int R_HI = RETRY_TICKS * D + 2;
  reg [4:0] st_q;
  reg [31:0] cnt_q;
  reg [31:0] low_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= 5'h01;
      cnt_q <= 32'h0;
      low_q <= 32'h0;
    end else begin
      st_q <= state_o;
      cnt_q <= (state_o != st_q) ? 32'h0 : cnt_q + 32'h1;
      low_q <= enable_input ? 32'h0 : low_q + 32'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_ov_held;
    input_overvoltage [*3] ##0
      (state_o == 5'h02 || state_o == 5'h04 || state_o == 5'h08);
  endsequence
  sequence s_left_retry;
    st_q == 5'h10 && state_o != 5'h10;
  endsequence
  a_ov_retry: assert property (s_ov_held |=> state_o == 5'h10)
    else $error("overvoltage did not enter retry");
  a_fault_alarm: assert property (s_ov_held |=> alarm_oe)
    else $error("fault did not pull alarm low");
  a_retry_off: assert property (state_o == 5'h10 |->
    !boost_en && !power_switch_en && current_sink_pin_en == '0)
    else $error("power path on in retry");
  a_sink_pwm: assert property (|current_sink_pin_en |->
    pwm_in && enable_input && state_o == 5'h08)
    else $error("sink on without pwm, enable and normal");
  a_pre_time: assert property (st_q == 5'h02 && state_o == 5'h04 |->
    cnt_q >= P_LO && cnt_q <= P_HI)
    else $error("precharge length wrong");
  a_ramp_time: assert property (st_q == 5'h04 && state_o == 5'h08 |->
    cnt_q >= A_LO && cnt_q <= A_HI)
    else $error("ramp length wrong");
  a_retry_time: assert property (s_left_retry |->
    cnt_q >= R_LO && cnt_q <= R_HI)
    else $error("retry length wrong");
  a_retry_dest: assert property (s_left_retry |->
    state_o == ($past(enable_input) ? 5'h02 : 5'h01))
    else $error("wrong state after retry");
  a_low_stby: assert property (low_q > STBY_CYC + 3 &&
    st_q != 5'h10 && state_o != 5'h10 |-> state_o == 5'h01)
    else $error("long enable low did not reach standby");
  a_stby_start: assert property (state_o == 5'h01 && enable_input |=>
    state_o == 5'h02)
    else $error("enable did not start precharge");
endmodule // lfs_supervisor_props

bind lfs_supervisor lfs_supervisor_props #(
  .NCH(NCH), .TICK_DIV(TICK_DIV), .PRE_TICKS(PRE_TICKS),
  .RAMP_TICKS(RAMP_TICKS), .RETRY_TICKS(RETRY_TICKS), .STBY_CYC(STBY_CYC)
) u_props (
  .clk(clk), .rst_b(rst_b), .enable_input(enable_input), .pwm_in(pwm_in),
  .input_overvoltage(input_overvoltage), .alarm_oe(alarm_oe),
  .boost_en(boost_en), .power_switch_en(power_switch_en),
  .current_sink_pin_en(current_sink_pin_en), .state_o(state_o)
);

// File: tb/lfs_host_model.sv
// Host controller: enable with clearing pulse, PWM source, alarm pull-up
`timescale 1ns/1ps
module lfs_host_model #(
  parameter int PWM_HALF = 2500,
  parameter int CLR_W = 1000
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Bench commands
  input wire en_cmd,
  input wire clr_go,
  // Device pins
  input wire alarm_out,
  input wire alarm_oe,
  output logic enable_input,
  output logic pwm_in,
  output wire alarm_in
);
  int pc_q;
  int cw_q;
  // Pull-up takes the alarm line high once the device lets go
  assign alarm_in = alarm_oe ? alarm_out : 1'b1;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_q <= 0;
      cw_q <= 0;
      pwm_in <= 1'b0;
      enable_input <= 1'b0;
    end else begin
      pc_q <= (pc_q == PWM_HALF - 1) ? 0 : pc_q + 1;
      if (pc_q == PWM_HALF - 1) pwm_in <= !pwm_in;
      if (clr_go) cw_q <= CLR_W;
      else if (cw_q != 0) cw_q <= cw_q - 1;
      enable_input <= en_cmd && cw_q == 0 && !clr_go;
    end
  end
endmodule // lfs_host_model

// File: tb/test_led_driver_fault_supervisor.sv
// Bench for the fault supervisor: host pins, flags and register bus
`timescale 1ns/1ps
module test_led_driver_fault_supervisor;
  localparam int D = 4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic en_cmd = 1'b0, clr_go = 1'b0, bmax = 1'b0, ce = 1'b1;
  logic [3:0] wstrb = 4'hF;
  logic [4:0] flt = 5'h00;
  logic [3:0] s_lo = 4'h0, s_mid = 4'h0, s_hi = 4'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, enable_input, pwm_in, alarm_in, alarm_out, alarm_oe;
  wire power_switch_en, boost_en;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] sink_en, loop_inc;
  wire [4:0] state_o;
  int n_errors = 0, total_checks = 0, cyc = 0, i;
  always #5 clk = ~clk;
  lfs_supervisor #(.TICK_DIV(D), .PRE_TICKS(20'h14), .RAMP_TICKS(20'h14),
    .RETRY_TICKS(20'h1E), .OVP_TICKS(20'h28)) DUT (
    .clk, .rst_b, .clk_en(ce), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(wstrb), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .enable_input, .pwm_in,
    .alarm_in, .alarm_out, .alarm_oe, .input_undervoltage(flt[0]),
    .input_overvoltage(flt[1]), .output_overvoltage(flt[2]),
    .inductor_node_overvoltage(flt[3]), .overtemperature_trip(flt[4]),
    .boost_at_max(bmax), .sink_low(s_lo), .sink_mid(s_mid),
    .sink_high(s_hi), .power_switch_en, .boost_en,
    .current_sink_pin_en(sink_en), .loop_include(loop_inc), .state_o);
  lfs_host_model u_host (.clk, .rst_b, .en_cmd, .clr_go, .alarm_out,
    .alarm_oe, .enable_input, .pwm_in, .alarm_in);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Ready flags are looked at on the falling edge, where they are settled
  task automatic axw(input [7:0] a, input [31:0] d, input [1:0] er);
    logic ta, tw, tb;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      if (tb) chk("bresp", 32'(s_axi_bresp), 32'(er));
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
  endtask
  task automatic axr(input [7:0] a, input [31:0] ed, input [1:0] er);
    logic ta, tr;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      if (tr) chk("rdata", s_axi_rdata, ed);
      if (tr) chk("rresp", 32'(s_axi_rresp), 32'(er));
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
  endtask
  task automatic wst(input [4:0] s);
    for (int n = 0; n < 9000 && state_o !== s; n++) @(negedge clk);
    chk("state", 32'(state_o), 32'(s));
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      test_done;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    axr(8'h00, 32'h1, 2'h0);
    axw(8'h00, 32'h0, 2'h0);
    axr(8'h00, 32'h0, 2'h0);
    axw(8'h00, 32'h1, 2'h0);
    wstrb <= 4'h0;
    axw(8'h00, 32'h0, 2'h0);
    axr(8'h00, 32'h1, 2'h0);
    wstrb <= 4'hF;
    axr(8'h40, 32'h0, 2'h3);
    axw(8'h40, 32'h5, 2'h3);
    axr(8'h04, 32'h101, 2'h0);
    $display("test registers done");
    s_lo <= 4'h8;
    en_cmd <= 1'b1;
    wst(5'h02);
    wst(5'h04);
    wst(5'h08);
    chk("loop", 32'(loop_inc), 32'h7);
    axr(8'h08, 32'h80000, 2'h0);
    s_lo <= 4'h0;
    $display("test startup done");
    // Hard faults one by one; the temperature one is held over a retry
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      flt <= 5'h01 << i;
      if (i == 2) repeat (40 * D - D - 8) @(negedge clk);
      if (i == 2) chk("ovp", 32'(state_o), 32'h8);
      wst(5'h10);
      chk("alarm", 32'(alarm_oe), 32'h1);
      chk("power", 32'({boost_en, power_switch_en, sink_en}), 32'h0);
      axr(8'h04, 32'h210, 2'h0);
      axr(8'h0C, 32'h1 << i, 2'h0);
      if (i == 4) wst(5'h02);
      if (i == 4) wst(5'h10);
      @(posedge clk);
      flt <= 5'h00;
      repeat (4) @(posedge clk);
      axw(8'h0C, 32'h1F, 2'h0);
      axr(8'h0C, 32'h0, 2'h0);
      wst(5'h08);
      chk("alarm", 32'(alarm_oe), 32'h0);
    end
    axr(8'h10, 32'h6, 2'h0);
    $display("test faults done");
    flt <= 5'h02;
    wst(5'h10);
    @(posedge clk);
    flt <= 5'h00;
    en_cmd <= 1'b0;
    wst(5'h01);
    @(posedge clk);
    en_cmd <= 1'b1;
    wst(5'h08);
    @(posedge clk);
    en_cmd <= 1'b0;
    repeat (4000) @(negedge clk);
    chk("early", 32'(state_o), 32'h8);
    wst(5'h01);
    @(posedge clk);
    en_cmd <= 1'b1;
    wst(5'h08);
    $display("test standby done");
    @(posedge clk);
    ce <= 1'b0;
    bmax <= 1'b1;
    s_lo <= 4'h2;
    repeat (8) @(negedge clk);
    chk("frozen", 32'(alarm_oe), 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    repeat (8) @(negedge clk);
    chk("alarm", 32'(alarm_oe), 32'h1);
    chk("state", 32'(state_o), 32'h8);
    chk("loop", 32'(loop_inc), 32'hD);
    chk("sinks", 32'(sink_en), 32'({4{pwm_in}} & 4'hD));
    axr(8'h08, 32'h2, 2'h0);
    bmax <= 1'b0;
    s_lo <= 4'h0;
    clr_go <= 1'b1;
    @(posedge clk);
    clr_go <= 1'b0;
    repeat (500) @(negedge clk);
    chk("blank", 32'(sink_en), 32'h0);
    repeat (600) @(negedge clk);
    chk("alarm", 32'(alarm_oe), 32'h0);
    chk("state", 32'(state_o), 32'h8);
    axr(8'h08, 32'h0, 2'h0);
    s_mid <= 4'h1;
    s_hi <= 4'h4;
    repeat (8) @(negedge clk);
    chk("alarm", 32'(alarm_oe), 32'h1);
    chk("loop", 32'(loop_inc), 32'hB);
    axr(8'h08, 32'h400, 2'h0);
    $display("test strings done");
    test_done;
  end
endmodule // test_led_driver_fault_supervisor
